// >>> rtl/compare_convert_exec.sv
/*
 Execution unit for the data-format conversion (trapped, never done in
 hardware) and the byte-match and equality compares, with a small
 register file and one interrupt line.
 Assumes a pipeline that issues one decoded instruction per ISSUE_I
 pulse and a plain synchronous register port.
*/
// Functional notes
// - Format fields are 2 bits: 00 integer, 01 single, 10 double, 11 reserved.
// - Rounding: 000 nearest, 001 down, 010 up, 011 zero, 100 from setting, 101-111 reserved.
// - With an integer side, unsigned select 0 means signed and 1 unsigned.
// - Conversion rounds the first operand into the destination format and register.
// - Hardware never converts; a conversion raises a dedicated trap for emulation.
// - The trap loads the source and destination pointers and the packed field word.
// - With unsigned select 1 the captured field includes the stack pointer added to it.
// - Double values use a register and its twin; single values use one register.
// - Byte-match compare writes TRUE if any same-position byte pair matches, else FALSE.
// - Equality compare writes TRUE when the full words are equal, else FALSE.
// - Immediate select picks the right register or a zero-extended 8-bit immediate.
`timescale 1ns/100ps
`default_nettype none
`include "cce_consts.svh"

module compare_convert_exec (
   input  wire logic                   REF_CLK_I,
   input  wire logic                   RESET_I,
   input  wire logic                   ISSUE_I,
   input  wire cce_pkg::op_type        OP_I,
   input  wire logic [7:0]             LEFT_IDX_I,
   input  wire logic [7:0]             RIGHT_IDX_I,
   input  wire logic [7:0]             RESULT_IDX_I,
   input  wire logic [31:0]            FIRST_OPERAND_I,
   input  wire logic [31:0]            RIGHT_REG_I,
   input  wire logic                   IMM_SEL_I,
   input  wire logic [7:0]             IMM_I,
   input  wire logic                   UNSIGNED_SEL_I,
   input  wire cce_pkg::rnd_type       ROUNDING_I,
   input  wire cce_pkg::fmt_type       DEST_FMT_I,
   input  wire cce_pkg::fmt_type       SRC_FMT_I,
   input  wire logic [31:0]            STACK_PTR_I,
   input  wire logic [7:0]             ADDR_I,
   input  wire logic [31:0]            WDATA_I,
   input  wire logic                   WR_I,
   input  wire logic                   RD_I,
   output logic [31:0]                 RDATA_O,
   output logic [31:0]                 RESULT_O,
   output logic [7:0]                  RESULT_IDX_O,
   output logic                        RESULT_WE_O,
   output logic                        TRAP_O,
   output logic [7:0]                  TRAP_A_PTR_O,
   output logic [31:0]                 TRAP_B_O,
   output logic [7:0]                  TRAP_DEST_PTR_O,
   output logic                        SRC_PAIR_O,
   output logic                        DEST_PAIR_O,
   output logic                        INT_UNSIGNED_O,
   output logic [1:0]                  ROUND_MODE_O,
   output logic                        IRQ_O
);
   import cce_pkg::*;

   function automatic logic fmt_bad(input fmt_type f);
      fmt_bad = (f == `FMT_RSVD);
   endfunction

   function automatic logic is_double(input fmt_type f);
      is_double = (f == `FMT_DOUBLE);
   endfunction

   logic [31:0]      result_ff;
   logic [7:0]       result_idx_ff;
   logic             result_we_ff;
   logic             trap_ff;
   logic [7:0]       trap_a_ff;
   logic [31:0]      trap_b_ff;
   logic [7:0]       trap_dest_ff;
   logic             src_pair_ff;
   logic             dest_pair_ff;
   logic             int_uns_ff;
   logic [1:0]       round_mode_ff;
   logic [`ST_W-1:0] status_ff;
   logic [`ST_W-1:0] mask_ff;
   logic [1:0]       round_set_ff;
   logic [31:0]      rdata_ff;
   logic             irq_ff;

   wire         do_conv  = ISSUE_I && (OP_I == OP_CONVERT);
   wire         do_byte  = ISSUE_I && (OP_I == OP_BYTE);
   wire         do_equal = ISSUE_I && (OP_I == OP_EQUAL);
   wire         do_cmp   = do_byte || do_equal;

   // Zero-extended immediate or right register
   wire [31:0]  second_operand = IMM_SEL_I ? {24'h000000, IMM_I} : RIGHT_REG_I;

   // Per-lane byte equality
   wire [3:0]   lane_eq;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : gen_lane
         assign lane_eq[g] = FIRST_OPERAND_I[8*g +: 8] == second_operand[8*g +: 8];
      end
   endgenerate

   wire         byte_hit  = |lane_eq;
   wire         word_hit  = FIRST_OPERAND_I == second_operand;
   wire         cmp_true  = do_byte ? byte_hit : word_hit;
   // Boolean is the top bit only; a true compare also sets status bit ST_CMP_TRUE
   wire [31:0]  cmp_value = cmp_true ? `BOOL_TRUE : `BOOL_FALSE;

   // Packed unsigned, rounding, destination, source fields
   wire [`FIELD_W-1:0] conv_field = {UNSIGNED_SEL_I, ROUNDING_I, DEST_FMT_I, SRC_FMT_I};
   // Stack pointer is folded in when unsigned; handler subtracts it
   wire [31:0]  sp_add   = UNSIGNED_SEL_I ? STACK_PTR_I : `ZERO32;
   wire [31:0]  trap_b_v = {24'h000000, conv_field} + sp_add;

   // Reserved and like-to-like formats are flagged, not acted on
   wire         fmt_err  = fmt_bad(SRC_FMT_I) || fmt_bad(DEST_FMT_I)
                           || (SRC_FMT_I == DEST_FMT_I);
   wire         rnd_err  = ROUNDING_I > `RND_USE_SET;
   // Setting register stands in for code 100
   wire [1:0]   rnd_eff  = (ROUNDING_I == `RND_USE_SET) ? round_set_ff : ROUNDING_I[1:0];
   // Integer interpretation only matters with an integer side
   wire         int_side = (SRC_FMT_I == `FMT_INT) || (DEST_FMT_I == `FMT_INT);

   // Register port decode
   wire         hit_status = ADDR_I == `REG_STATUS;
   wire         hit_mask   = ADDR_I == `REG_MASK;
   wire         hit_rset   = ADDR_I == `REG_ROUND_SET;
   wire         hit_ta     = ADDR_I == `REG_TRAP_A;
   wire         hit_tb     = ADDR_I == `REG_TRAP_B;
   wire         hit_td     = ADDR_I == `REG_TRAP_DEST;

   wire [31:0]  rd_mux = hit_status ? {28'h0000000, status_ff} :
                         hit_mask   ? {28'h0000000, mask_ff} :
                         hit_rset   ? {30'h0, round_set_ff} :
                         hit_ta     ? {24'h000000, trap_a_ff} :
                         hit_tb     ? trap_b_ff :
                         hit_td     ? {24'h000000, trap_dest_ff} : `ZERO32;

   wire [`ST_W-1:0] events;
   assign events[`ST_TRAP]     = do_conv;
   assign events[`ST_CMP_TRUE] = do_cmp && cmp_true;
   assign events[`ST_BAD_FMT]  = do_conv && fmt_err;
   assign events[`ST_BAD_RND]  = do_conv && rnd_err;

   // Write-one clears, but a same-cycle event wins
   wire [`ST_W-1:0] w1c = (WR_I && hit_status) ? WDATA_I[`ST_W-1:0] : `ST_RESET;
   wire [`ST_W-1:0] nxt_status = (status_ff & ~w1c) | events;
   wire [`ST_W-1:0] nxt_mask   = (WR_I && hit_mask) ? WDATA_I[`ST_W-1:0] : mask_ff;
   wire [1:0]       nxt_rset   = (WR_I && hit_rset) ? WDATA_I[1:0] : round_set_ff;
   wire             nxt_irq    = |(nxt_status & mask_ff);
   wire [31:0]      nxt_rdata  = RD_I ? rd_mux : `ZERO32;

   // Status events win over a same-cycle clear
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         status_ff <= `ST_RESET;
      end else begin
         status_ff <= nxt_status;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         mask_ff <= `ST_RESET;
      end else begin
         mask_ff <= nxt_mask;
      end
   end

   // Setting used when the rounding code defers to it
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         round_set_ff <= `RND_SET_RESET;
      end else begin
         round_set_ff <= nxt_rset;
      end
   end

   // Read data stands one cycle, zero otherwise
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         rdata_ff <= `ZERO32;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // Registered so the interrupt pin comes straight from a flop
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         irq_ff <= `BIT_RESET;
      end else begin
         irq_ff <= nxt_irq;
      end
   end

   // Write-back strobe pulses one cycle after each compare issue
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         result_we_ff <= `BIT_RESET;
      end else begin
         result_we_ff <= do_cmp;
      end
   end

   // Result holds until the next compare; conversion never writes
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         result_ff <= `ZERO32;
      end else if (do_cmp) begin
         result_ff <= cmp_value;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         result_idx_ff <= `IDX_RESET;
      end else if (do_cmp) begin
         result_idx_ff <= RESULT_IDX_I;
      end
   end

   // Conversion is handed to software via the trap
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         trap_ff <= `BIT_RESET;
      end else begin
         trap_ff <= do_conv;
      end
   end

   // Trap capture holds until the next conversion issue
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         trap_a_ff <= `IDX_RESET;
      end else if (do_conv) begin
         trap_a_ff <= LEFT_IDX_I;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         trap_dest_ff <= `IDX_RESET;
      end else if (do_conv) begin
         trap_dest_ff <= RESULT_IDX_I;
      end
   end

   // Handler must undo the stack pointer addition itself
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         trap_b_ff <= `ZERO32;
      end else if (do_conv) begin
         trap_b_ff <= trap_b_v;
      end
   end

   // Pair flags only; twin numbering is left to the handler
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         src_pair_ff <= `BIT_RESET;
      end else if (do_conv) begin
         src_pair_ff <= is_double(SRC_FMT_I);
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         dest_pair_ff <= `BIT_RESET;
      end else if (do_conv) begin
         dest_pair_ff <= is_double(DEST_FMT_I);
      end
   end

   // Float-only conversions report signed, whatever the select bit
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         int_uns_ff <= `BIT_RESET;
      end else if (do_conv) begin
         int_uns_ff <= int_side && UNSIGNED_SEL_I;
      end
   end

   // Reserved codes pass their low bits; the status bit flags them
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         round_mode_ff <= `RND_SET_RESET;
      end else if (do_conv) begin
         round_mode_ff <= rnd_eff;
      end
   end

   assign RDATA_O         = rdata_ff;
   assign RESULT_O        = result_ff;
   assign RESULT_IDX_O    = result_idx_ff;
   assign RESULT_WE_O     = result_we_ff;
   assign TRAP_O          = trap_ff;
   assign TRAP_A_PTR_O    = trap_a_ff;
   assign TRAP_B_O        = trap_b_ff;
   assign TRAP_DEST_PTR_O = trap_dest_ff;
   assign SRC_PAIR_O      = src_pair_ff;
   assign DEST_PAIR_O     = dest_pair_ff;
   assign INT_UNSIGNED_O  = int_uns_ff;
   assign ROUND_MODE_O    = round_mode_ff;
   assign IRQ_O           = irq_ff;
endmodule
`default_nettype wire

// >>> rtl/cce_consts.svh
/*
 Constants for the compare and convert execution block: register
 offsets, field positions, status bits and encodings.
 Assumes inclusion by bare name from the package and the design.
*/
`ifndef CCE_CONSTS_SVH
`define CCE_CONSTS_SVH

`define REG_ADDR_W      8
`define REG_STATUS      8'h00
`define REG_MASK        8'h04
`define REG_ROUND_SET   8'h08
`define REG_TRAP_A      8'h0C
`define REG_TRAP_B      8'h10
`define REG_TRAP_DEST   8'h14

`define ST_W            4
`define ST_TRAP         0
`define ST_CMP_TRUE     1
`define ST_BAD_FMT      2
`define ST_BAD_RND      3
`define ST_RESET        4'h0
`define BIT_RESET       1'b0
`define IDX_RESET       8'h00

`define FMT_INT         2'h0
`define FMT_SINGLE      2'h1
`define FMT_DOUBLE      2'h2
`define FMT_RSVD        2'h3

`define RND_NEAREST     3'h0
`define RND_MINUS       3'h1
`define RND_PLUS        3'h2
`define RND_ZERO        3'h3
`define RND_USE_SET     3'h4
`define RND_SET_RESET   2'h0

`define BOOL_TRUE       32'h80000000
`define BOOL_FALSE      32'h00000000
`define IMM_W           8
`define FIELD_W         8
`define ZERO32          32'h00000000

`endif

// >>> rtl/cce_pkg.sv
/*
 Types shared by the compare and convert execution block.
 Assumes cce_consts.svh is on the include path.
*/
package cce_pkg;
`include "cce_consts.svh"

   typedef enum logic [2:0] {
      OP_CONVERT = 3'b001,
      OP_BYTE    = 3'b010,
      OP_EQUAL   = 3'b100
   } op_type;

   typedef logic [1:0] fmt_type;
   typedef logic [2:0] rnd_type;
endpackage

// >>> tb/cce_monitor.sv
/* Port assertions for compare_convert_exec.
   Assumes cce_pkg is compiled first; bound to every instance. */
`timescale 1ns/100ps
`default_nettype none
`include "cce_consts.svh"
module cce_monitor
   import cce_pkg::*;
(
   input wire logic             REF_CLK_I,
   input wire logic             RESET_I,
   input wire logic             ISSUE_I,
   input wire cce_pkg::op_type  OP_I,
   input wire logic [7:0]       LEFT_IDX_I,
   input wire logic [7:0]       RESULT_IDX_I,
   input wire logic [31:0]      FIRST_OPERAND_I,
   input wire logic [31:0]      RIGHT_REG_I,
   input wire logic             IMM_SEL_I,
   input wire logic [7:0]       IMM_I,
   input wire logic             UNSIGNED_SEL_I,
   input wire cce_pkg::rnd_type ROUNDING_I,
   input wire cce_pkg::fmt_type DEST_FMT_I,
   input wire cce_pkg::fmt_type SRC_FMT_I,
   input wire logic [31:0]      STACK_PTR_I,
   input wire logic [31:0]      RESULT_O,
   input wire logic             RESULT_WE_O,
   input wire logic             TRAP_O,
   input wire logic [7:0]       TRAP_A_PTR_O,
   input wire logic [31:0]      TRAP_B_O,
   input wire logic [7:0]       TRAP_DEST_PTR_O,
   input wire logic             SRC_PAIR_O,
   input wire logic             DEST_PAIR_O,
   input wire logic [1:0]       ROUND_MODE_O
);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RESET_I);
   wire logic [31:0] sec = IMM_SEL_I ? {24'h0, IMM_I} : RIGHT_REG_I;
   wire logic [7:0]  ctl = {UNSIGNED_SEL_I, ROUNDING_I, DEST_FMT_I, SRC_FMT_I};
   wire logic [31:0] trap_b = {24'h0, ctl} + (UNSIGNED_SEL_I ? STACK_PTR_I : 32'h0);
   wire logic [1:0]  rnd_lo = ROUNDING_I[1:0];
   wire logic        same = FIRST_OPERAND_I == sec;
   wire logic        hit = (FIRST_OPERAND_I[7:0] == sec[7:0])
      || (FIRST_OPERAND_I[15:8] == sec[15:8])
      || (FIRST_OPERAND_I[23:16] == sec[23:16])
      || (FIRST_OPERAND_I[31:24] == sec[31:24]);
   sequence conv_s; ISSUE_I && OP_I == OP_CONVERT; endsequence
   sequence byte_s; ISSUE_I && OP_I == OP_BYTE; endsequence
   sequence eq_s; ISSUE_I && OP_I == OP_EQUAL; endsequence
   trap_pulse_a: assert property (conv_s |=> TRAP_O && !RESULT_WE_O)
      else $error("convert issue gave no trap");
   trap_quiet_a: assert property (!(ISSUE_I && OP_I == OP_CONVERT) |=> !TRAP_O)
      else $error("trap without convert issue");
   trap_ptr_a: assert property (conv_s |=> TRAP_A_PTR_O == $past(LEFT_IDX_I)
      && TRAP_DEST_PTR_O == $past(RESULT_IDX_I)) else $error("trap pointers wrong");
   trap_field_a: assert property (conv_s |=> TRAP_B_O == $past(trap_b))
      else $error("trap field word wrong");
   pair_flag_a: assert property (conv_s |=>
      SRC_PAIR_O == $past(SRC_FMT_I == `FMT_DOUBLE)
      && DEST_PAIR_O == $past(DEST_FMT_I == `FMT_DOUBLE)) else $error("pair flag wrong");
   round_code_a: assert property (conv_s ##0 ROUNDING_I < `RND_USE_SET
      |=> ROUND_MODE_O == $past(rnd_lo)) else $error("round mode wrong");
   byte_match_a: assert property (byte_s |=> RESULT_WE_O
      && RESULT_O == ($past(hit) ? `BOOL_TRUE : `BOOL_FALSE)) else $error("byte match wrong");
   equal_cmp_a: assert property (eq_s |=> RESULT_WE_O
      && RESULT_O == ($past(same) ? `BOOL_TRUE : `BOOL_FALSE)) else $error("equality wrong");
endmodule
bind compare_convert_exec cce_monitor i_cce_monitor (.*);
`default_nettype wire

// >>> tb/pipe_model.sv
/* Register file of the issuing pipeline: operand contents out,
   compare results back. Assumes 8-bit register numbers. */
`timescale 1ns/100ps
`default_nettype none
module pipe_model (
   input  wire logic        clk_i,
   input  wire logic [7:0]  left_idx_i,
   input  wire logic [7:0]  right_idx_i,
   input  wire logic [7:0]  wr_idx_i,
   input  wire logic [31:0] wr_data_i,
   input  wire logic        wr_en_i,
   output logic [31:0]      left_o,
   output logic [31:0]      right_o
);
   logic [31:0] regs [256];
   assign left_o = regs[left_idx_i];
   assign right_o = regs[right_idx_i];
   // Plain always: the bench preloads entries directly
   always @(posedge clk_i) begin
      if (wr_en_i) begin
         regs[wr_idx_i] <= wr_data_i;
      end
   end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/* Self-checking bench for compare_convert_exec.
   Assumes the rtl package and header are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "cce_consts.svh"
module tb_top;
   import cce_pkg::*;
   logic REF_CLK_I, RESET_I, ISSUE_I, IMM_SEL_I, UNSIGNED_SEL_I, WR_I, RD_I;
   logic RESULT_WE_O, TRAP_O, SRC_PAIR_O, DEST_PAIR_O, INT_UNSIGNED_O, IRQ_O;
   op_type OP_I;
   rnd_type ROUNDING_I;
   fmt_type DEST_FMT_I, SRC_FMT_I;
   logic [1:0] ROUND_MODE_O;
   logic [7:0] LEFT_IDX_I, RIGHT_IDX_I, RESULT_IDX_I, IMM_I, ADDR_I, ctl;
   logic [7:0] RESULT_IDX_O, TRAP_A_PTR_O, TRAP_DEST_PTR_O;
   logic [31:0] STACK_PTR_I, WDATA_I, RDATA_O, RESULT_O, TRAP_B_O;
   wire logic [31:0] FIRST_OPERAND_I, RIGHT_REG_I;
   logic [3:0] fmts [5] = '{4'h4, 4'h8, 4'h1, 4'h6, 4'h8};
   int error_cnt = 0;
   int checks_done = 0;
   localparam logic [31:0] SP = 32'h00001000;
   compare_convert_exec i_compare_convert_exec (.*);
   pipe_model i_pipe_model (.clk_i(REF_CLK_I), .left_idx_i(LEFT_IDX_I),
      .right_idx_i(RIGHT_IDX_I), .wr_idx_i(RESULT_IDX_O), .wr_data_i(RESULT_O),
      .wr_en_i(RESULT_WE_O), .left_o(FIRST_OPERAND_I), .right_o(RIGHT_REG_I));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         error_cnt++;
      end
   endtask
   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge REF_CLK_I);
      ADDR_I <= a;
      WDATA_I <= d;
      WR_I <= 1'b1;
      @(posedge REF_CLK_I);
      WR_I <= 1'b0;
   endtask
   task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge REF_CLK_I);
      ADDR_I <= a;
      RD_I <= 1'b1;
      @(posedge REF_CLK_I);
      RD_I <= 1'b0;
      #1 chk(RDATA_O, exp);
   endtask
   task automatic issue(input op_type op, input logic [7:0] a, b, c, input logic m,
                        input logic [7:0] imm, k);
      @(posedge REF_CLK_I);
      ISSUE_I <= 1'b1;
      OP_I <= op;
      {LEFT_IDX_I, RIGHT_IDX_I, RESULT_IDX_I, IMM_SEL_I, IMM_I} <= {a, b, c, m, imm};
      {UNSIGNED_SEL_I, ROUNDING_I, DEST_FMT_I, SRC_FMT_I} <= k;
      @(posedge REF_CLK_I);
      ISSUE_I <= 1'b0;
      #1;
   endtask
   task automatic cmp(input op_type op, input logic [7:0] a, b, input logic m,
                      input logic [7:0] imm, input logic t);
      issue(op, a, b, 8'h09, m, imm, 8'h00);
      chk(32'(RESULT_WE_O), 32'h1);
      chk(RESULT_O, t ? `BOOL_TRUE : `BOOL_FALSE);
   endtask
   initial begin
      REF_CLK_I = 1'b0;
      forever #4 REF_CLK_I = ~REF_CLK_I;
   end
   // Whole run needs under a hundred cycles
   initial begin
      repeat (20000) @(posedge REF_CLK_I);
      error_cnt++;
      wrap_up();
   end
   initial begin
      RESET_I = 1'b1;
      OP_I = OP_EQUAL;
      STACK_PTR_I = SP;
      {ISSUE_I, IMM_SEL_I, WR_I, RD_I, LEFT_IDX_I, RIGHT_IDX_I, RESULT_IDX_I} = '0;
      {IMM_I, ADDR_I, WDATA_I, UNSIGNED_SEL_I, ROUNDING_I, DEST_FMT_I, SRC_FMT_I} = '0;
      i_pipe_model.regs[1] = 32'h11223344;
      i_pipe_model.regs[2] = 32'h55663377;
      i_pipe_model.regs[3] = 32'h44332211;
      i_pipe_model.regs[4] = 32'h00000000;
      i_pipe_model.regs[5] = 32'h00FFFFFF;
      i_pipe_model.regs[6] = 32'h11223345;
      i_pipe_model.regs[7] = 32'h000000FF;
      repeat (16) @(posedge REF_CLK_I);
      RESET_I <= 1'b0;
      reg_chk(`REG_STATUS, 32'h0);
      reg_chk(`REG_MASK, 32'h0);
      reg_chk(8'hFC, 32'h0);
      reg_wr(`REG_ROUND_SET, 32'h2);
      reg_chk(`REG_ROUND_SET, 32'h2);
      $display("register test done");
      cmp(OP_BYTE, 8'h01, 8'h02, 1'b0, 8'h00, 1'b1);
      cmp(OP_BYTE, 8'h01, 8'h03, 1'b0, 8'h00, 1'b0);
      cmp(OP_BYTE, 8'h04, 8'h05, 1'b0, 8'h00, 1'b1);
      cmp(OP_BYTE, 8'h01, 8'h00, 1'b1, 8'h44, 1'b1);
      cmp(OP_BYTE, 8'h01, 8'h02, 1'b1, 8'h00, 1'b0);
      cmp(OP_EQUAL, 8'h01, 8'h06, 1'b0, 8'h00, 1'b0);
      cmp(OP_EQUAL, 8'h05, 8'h00, 1'b1, 8'hFF, 1'b0);
      cmp(OP_EQUAL, 8'h01, 8'h01, 1'b0, 8'h00, 1'b1);
      cmp(OP_EQUAL, 8'h07, 8'h00, 1'b1, 8'hFF, 1'b1);
      @(posedge REF_CLK_I);
      #1 chk(i_pipe_model.regs[9], `BOOL_TRUE);
      reg_chk(`REG_STATUS, 32'h2);
      reg_wr(`REG_STATUS, 32'h2);
      reg_chk(`REG_STATUS, 32'h0);
      $display("compare test done");
      reg_wr(`REG_MASK, 32'h1);
      for (int r = 0; r < 5; r++) begin
         ctl = {r[0], r[2:0], fmts[r]};
         issue(OP_CONVERT, 8'h21, 8'h00, 8'h31, 1'b0, 8'h00, ctl);
         chk(32'({TRAP_O, RESULT_WE_O}), 32'h2);
         chk(32'({TRAP_A_PTR_O, TRAP_DEST_PTR_O}), 32'h2131);
         chk(TRAP_B_O - (r[0] ? SP : 32'h0), {24'h0, ctl});
         chk(32'({SRC_PAIR_O, DEST_PAIR_O}),
             32'({fmts[r][1:0] == `FMT_DOUBLE, fmts[r][3:2] == `FMT_DOUBLE}));
         chk(32'(INT_UNSIGNED_O), 32'(r[0] &&
             (fmts[r][1:0] == `FMT_INT || fmts[r][3:2] == `FMT_INT)));
         chk(32'(ROUND_MODE_O), (r == 4) ? 32'h2 : 32'(r[1:0]));
         chk(RESULT_O, `BOOL_TRUE);
      end
      @(posedge REF_CLK_I);
      #1 chk(32'({TRAP_O, IRQ_O}), 32'h1);
      issue(OP_CONVERT, 8'h21, 8'h00, 8'h31, 1'b0, 8'h00, 8'h55);
      chk(32'(TRAP_O), 32'h1);
      reg_chk(`REG_STATUS, 32'hD);
      reg_chk(`REG_TRAP_A, 32'h21);
      reg_chk(`REG_TRAP_B, 32'h55);
      reg_chk(`REG_TRAP_DEST, 32'h31);
      reg_wr(`REG_MASK, 32'h0);
      @(posedge REF_CLK_I);
      #1 chk(32'(IRQ_O), 32'h0);
      reg_wr(`REG_MASK, 32'h1);
      reg_wr(`REG_STATUS, 32'hF);
      reg_chk(`REG_STATUS, 32'h0);
      chk(32'(IRQ_O), 32'h0);
      $display("convert test done");
      wrap_up();
   end
endmodule
`default_nettype wire
